// File: common/modem_port_defs.vh
// Register map, field positions and reset values of the modem serial ports
`ifndef MODEM_PORT_DEFS_VH
`define MODEM_PORT_DEFS_VH

`define ADDR_MODEM_CONFIG_C    8'h08
`define ADDR_IO_POLARITY       8'h24
`define ADDR_TX_CONTROL        8'h40
`define ADDR_BIT_HALF_PERIOD   8'h44
`define ADDR_ENERGY_THRESHOLD  8'h48
`define ADDR_PORT_STATUS       8'h4C

`define CFGC_CRC_IGNORE_BIT    5

`define POL_TX_READY_LOW_BIT   0
`define POL_TX_ENABLE_LOW_BIT  1
`define POL_TX_CLOCK_LOW_BIT   2
`define POL_RX_VALID_LOW_BIT   6

`define TXC_INT_PREAMBLE_BIT   0
`define TXC_LEAD_LSB           8
`define TXC_LEAD_MSB           15
`define TXC_PRE_LEN_LSB        16
`define TXC_PRE_LEN_MSB        31

`define RST_MODEM_CONFIG_C     8'h00
`define RST_IO_POLARITY        8'h00
`define RST_TX_CONTROL         32'h0080_0001
`define RST_BIT_HALF_PERIOD    16'h0008
`define RST_ENERGY_THRESHOLD   6'h20

`define AXI_RESP_OKAY          2'b00
`define AXI_RESP_SLVERR        2'b10

`endif

// File: tb/mac_partner.sv
// Processor model driving the transmit pins
module mac_partner (
    input wire logic  clk_sys,
    input wire logic  rst,
    input wire logic  go,
    input wire logic  en_low,
    input wire logic  clk_inv,
    input wire logic  tx_bit_clock_out,
    output logic      tx_power_enable,
    output logic      tx_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] lfsr;
    logic        prev;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lfsr <= 16'hace1;
            prev <= 1'b0;
            tx_power_enable <= en_low;
            tx_data_in <= 1'b0;
        end else begin
            prev <= tx_bit_clock_out ^ clk_inv;
            tx_power_enable <= go ^ en_low;
            if (!go) begin
                tx_data_in <= ~tx_data_in;
            end else if ((tx_bit_clock_out ^ clk_inv) && !prev) begin
                lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13]};
                tx_data_in <= lfsr[0];
            end
        end
    end
endmodule

// File: tb/modem_ports_props.sv
// Port assertions for the modem serial ports
module modem_ports_props (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        tx_bit_strobe,
    input wire logic        rx_power_enable,
    input wire logic        acq_achieved,
    input wire logic        carrier_acquired_ind,
    input wire logic        rx_bit_clock_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_aw_pulse:
        assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_wr_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bvalid_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rvalid_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_unmapped:
        assert property (s_axi_arvalid && s_axi_arready && !(s_axi_araddr
            inside {8'h08, 8'h24, 8'h40, 8'h44, 8'h48, 8'h4C}) |=>
            s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 0)
        else $error("unmapped read not refused");
    a_strobe_pulse:
        assert property (tx_bit_strobe |=> !tx_bit_strobe)
        else $error("bit strobe longer than one cycle");
    a_carrier_standby:
        assert property (!rx_power_enable [*4] |-> !carrier_acquired_ind)
        else $error("carrier sense while receive off");
    a_carrier_acq:
        assert property (!acq_achieved [*3] |-> !carrier_acquired_ind)
        else $error("carrier sense without acquisition");
    a_rx_bit_clock_out_stops:
        assert property (!acq_achieved [*4] |-> $stable(rx_bit_clock_out))
        else $error("receive clock runs without acquisition");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (tx_bit_strobe);
    cover property ($rose(carrier_acquired_ind));
endmodule

bind modem_serial_tx_rx_ports modem_ports_props i_props (.*);

// File: tb/modem_serial_tx_rx_ports_tb_top.sv
// Self-checking bench for the modem serial ports
`include "modem_port_defs.vh"
module modem_serial_tx_rx_ports_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst, go, s_axi_awvalid, s_axi_wvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, pol;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, tx_power_enable;
    logic        tx_data_in, tx_bit_clock_out, tx_ready;
    logic        clear_channel_ind, tx_bit_out, tx_bit_strobe;
    logic        tx_data_phase, rx_power_enable, rx_bit_clock_out;
    logic        rx_data_out, rx_data_valid, energy_detect_ind;
    logic        carrier_acquired_ind, acq_achieved, pn_track_lost;
    logic        demod_bit, demod_strobe, hdr_strobe, hdr_crc_ok, b;
    logic [15:0] hdr_length;
    logic [5:0]  rssi_value, thr;
    logic [7:0]  ra [6] = '{8'h08, 8'h24, 8'h40, 8'h44, 8'h48, 8'h4C};
    logic [31:0] rv [6] = '{0, 0, 32'h0080_0001, 32'h0000_0008,
                            32'h0000_0020, 0};
    int          fail_count, tests_run, seed, k, p;

    modem_serial_tx_rx_ports i_dut (.*);
    mac_partner i_mac (.clk_sys, .rst, .go, .en_low(pol[1]),
        .clk_inv(pol[2]), .tx_bit_clock_out, .tx_power_enable, .tx_data_in);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) demod_strobe <= 1'($random(seed));

    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", s_axi_rresp, r);
    endtask

    task automatic tx_frame(input logic intl);
        int npre;
        npre = 0;
        rssi_value <= 6'h3f;
        go <= 1'b1;
        repeat (12) begin
            do @(posedge clk_sys); while (tx_bit_strobe !== 1'b1);
            if (!tx_data_phase) begin
                npre++;
                chk("pre_bit", tx_bit_out, 1'b1);
                chk("rdy_lead", tx_ready ^ pol[0], npre >= 5);
            end else begin
                chk("tx_bit", tx_bit_out, tx_data_in);
                chk("rx_in_tx", carrier_acquired_ind, 1'b1);
                chk("tx_rdy", tx_ready ^ pol[0], intl);
            end
        end
        go <= 1'b0;
        chk("pre_len", npre, intl ? 6 : 0);
        repeat (8) @(posedge clk_sys);
        chk("clk_idle", tx_bit_clock_out ^ pol[2], 1'b0);
    endtask

    task automatic rx_hdr(input logic [15:0] len, input logic crc, expv,
                          input int stop);
        int n;
        n = 0;
        demod_bit <= 1'($random(seed));
        hdr_length <= len;
        hdr_crc_ok <= crc;
        hdr_strobe <= 1'b1;
        @(posedge clk_sys);
        hdr_strobe <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("valid_on", rx_data_valid ^ pol[6], expv);
        if (stop == 1) pn_track_lost <= 1'b1;
        if (stop == 2) rx_power_enable <= 1'b0;
        while ((rx_data_valid ^ pol[6]) && n < 400) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n == 40) chk("rx_bit", rx_data_out, demod_bit);
        end
        if (stop == 0 && expv) chk("valid_len", (n - 1) / 16, len);
        if (stop != 0) chk("valid_drop", n <= 5, 1'b1);
        if (stop == 2) begin
            repeat (3) @(posedge clk_sys);
            chk("carrier_off", carrier_acquired_ind, 1'b0);
        end
        pn_track_lost <= 1'b0;
        rx_power_enable <= 1'b1;
        repeat (40) @(posedge clk_sys);
    endtask

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        final_report;
    end

    initial begin
        seed = 32'heb7c;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, go} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, hdr_length, rssi_value, pol} = '0;
        {rx_power_enable, acq_achieved, pn_track_lost, demod_bit} = '0;
        {hdr_strobe, hdr_crc_ok} = '0;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (k = 0; k < 6; k++) rd(ra[k], rv[k], `AXI_RESP_OKAY);
        rd(8'h10, 0, `AXI_RESP_SLVERR);
        wr(8'h10, 32'hffff_ffff, `AXI_RESP_SLVERR);
        for (k = 0; k < 8; k++) begin
            thr = 6'($random(seed));
            wr(`ADDR_ENERGY_THRESHOLD, {26'h0, thr}, `AXI_RESP_OKAY);
            rssi_value <= (k % 2) ? thr : 6'($random(seed));
            repeat (4) @(posedge clk_sys);
            chk("ed", energy_detect_ind, rssi_value > thr);
            chk("cca", clear_channel_ind, rssi_value <= thr);
        end
        rd(`ADDR_ENERGY_THRESHOLD, {26'h0, thr}, `AXI_RESP_OKAY);
        for (p = 0; p < 2; p++) begin
            pol <= p ? 8'h47 : 8'h00;
            wr(`ADDR_IO_POLARITY, p ? 32'h0000_0047 : 0, `AXI_RESP_OKAY);
            repeat (20) @(posedge clk_sys);
            rx_power_enable <= 1'b1;
            acq_achieved <= 1'b1;
            wr(`ADDR_TX_CONTROL, 32'h0000_0000, `AXI_RESP_OKAY);
            tx_frame(1'b0);
            wr(`ADDR_TX_CONTROL, 32'h0006_0201, `AXI_RESP_OKAY);
            tx_frame(1'b1);
            b = rx_bit_clock_out;
            repeat (8) @(posedge clk_sys);
            chk("rx_clk", rx_bit_clock_out ^ b, 1'b1);
            chk("valid_idle", rx_data_valid ^ pol[6], 0);
            chk("carrier", carrier_acquired_ind, 1'b1);
            wr(`ADDR_MODEM_CONFIG_C, 0, `AXI_RESP_OKAY);
            rx_hdr(16'(3 + {$random(seed)} % 4), 1'b1, 1'b1, 0);
            rx_hdr(16'd3, 1'b0, 1'b0, 0);
            wr(`ADDR_MODEM_CONFIG_C, 32'h0000_0020, `AXI_RESP_OKAY);
            rx_hdr(16'd4, 1'b0, 1'b1, 0);
            rx_hdr(16'd8, 1'b1, 1'b1, 1);
            rx_hdr(16'd8, 1'b1, 1'b1, 2);
            acq_achieved <= 1'b0;
        end
        final_report;
    end
endmodule

// File: verilog/modem_serial_tx_rx_ports.v
// Serial transmit and receive ports of the modem with AXI4-Lite registers
//
// Behaviour
// - device drives bit clock, samples data falling
// - bit clock runs while transmit enable active
// - internal mode sends preamble after enable
// - internal mode raises ready during preamble, lead bits before its end
// - ready lead time is programmable
// - external mode sends data at once
// - clear channel output never gates transmit
// - ready, enable, clock polarities each programmable
// - transmit port independent of receive port
// - demodulated bits leave with receive clock
// - receive disabled stops clock, valid and carrier sense; energy detect keeps running
// - data valid frames exactly the valid bits
// - optional ignore of header CRC failure
// - receive clock starts at acquisition
// - valid drops on length, lost track, disable
// - data valid polarity is programmable
// - energy detect and carrier sense outputs
// - receive port independent of transmit port
// - energy detect when strength above threshold
// - carrier sense when acquisition achieved
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`include "modem_port_defs.vh"

module modem_serial_tx_rx_ports (
    input  wire        clk_sys,
    input  wire        rst,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Transmit pins
    input  wire        tx_power_enable,
    input  wire        tx_data_in,
    output reg         tx_bit_clock_out,
    output reg         tx_ready,
    output reg         clear_channel_ind,
    // Transmit stream to modulator core
    output reg         tx_bit_out,
    output reg         tx_bit_strobe,
    output reg         tx_data_phase,
    // Receive pins
    input  wire        rx_power_enable,
    output reg         rx_bit_clock_out,
    output reg         rx_data_out,
    output reg         rx_data_valid,
    output reg         energy_detect_ind,
    output reg         carrier_acquired_ind,
    // Receive side of demodulator core
    input  wire        acq_achieved,
    input  wire        pn_track_lost,
    input  wire        demod_bit,
    input  wire        demod_strobe,
    input  wire        hdr_strobe,
    input  wire [15:0] hdr_length,
    input  wire        hdr_crc_ok,
    input  wire [5:0]  rssi_value
);

localparam [1:0] TX_IDLE     = 2'd0;
localparam [1:0] TX_PREAMBLE = 2'd1;
localparam [1:0] TX_DATA     = 2'd2;

// Half-period divider step shared by both ports
function [15:0] div_next;
    input [15:0] count;
    input [15:0] half;
    begin
        if (count == 16'h0000)
            div_next = half - 16'h0001;
        else
            div_next = count - 16'h0001;
    end
endfunction

reg  [7:0]  modem_config_c;
reg  [7:0]  io_polarity_config;
reg  [31:0] tx_control;
reg  [15:0] bit_half_period;
reg  [5:0]  energy_threshold;

wire [2:0]  pins_sync;
wire        tx_power_enable_eff;
wire        rx_power_enable_eff;
wire        tx_data_sync;
wire [15:0] half_eff;

sync_two_flop #(
    .WIDTH (3)
) u_pin_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({rx_power_enable, tx_data_in, tx_power_enable}),
    .sync_out (pins_sync)
);

assign tx_power_enable_eff    = pins_sync[0] ^
                      io_polarity_config[`POL_TX_ENABLE_LOW_BIT];
assign tx_data_sync = pins_sync[1];
assign rx_power_enable_eff    = pins_sync[2];
assign half_eff     = (bit_half_period == 16'h0000) ? 16'h0001
                                                    : bit_half_period;

// AXI4-Lite write path: address and data taken in either order
reg        aw_held;
reg        w_held;
reg [7:0]  aw_addr;
reg [31:0] w_data;
reg [3:0]  w_strb;
wire       do_write;
reg        wr_ok;

assign do_write = aw_held && w_held && !s_axi_bvalid;

always @* begin
    case (aw_addr)
        `ADDR_MODEM_CONFIG_C,
        `ADDR_IO_POLARITY,
        `ADDR_TX_CONTROL,
        `ADDR_BIT_HALF_PERIOD,
        `ADDR_ENERGY_THRESHOLD: wr_ok = 1'b1;
        default:                wr_ok = 1'b0;
    endcase
end

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        aw_held            <= 1'b0;
        w_held             <= 1'b0;
        aw_addr            <= 8'h00;
        w_data             <= 32'h0000_0000;
        w_strb             <= 4'h0;
        s_axi_awready      <= 1'b0;
        s_axi_wready       <= 1'b0;
        s_axi_bvalid       <= 1'b0;
        s_axi_bresp        <= `AXI_RESP_OKAY;
        modem_config_c     <= `RST_MODEM_CONFIG_C;
        io_polarity_config <= `RST_IO_POLARITY;
        tx_control         <= `RST_TX_CONTROL;
        bit_half_period    <= `RST_BIT_HALF_PERIOD;
        energy_threshold   <= `RST_ENERGY_THRESHOLD;
    end else begin
        s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
        s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            case (aw_addr)
                `ADDR_MODEM_CONFIG_C:
                    if (w_strb[0]) modem_config_c <= w_data[7:0];
                `ADDR_IO_POLARITY:
                    if (w_strb[0]) io_polarity_config <= w_data[7:0];
                `ADDR_TX_CONTROL: begin
                    if (w_strb[0]) tx_control[7:0]   <= w_data[7:0];
                    if (w_strb[1]) tx_control[15:8]  <= w_data[15:8];
                    if (w_strb[2]) tx_control[23:16] <= w_data[23:16];
                    if (w_strb[3]) tx_control[31:24] <= w_data[31:24];
                end
                `ADDR_BIT_HALF_PERIOD: begin
                    if (w_strb[0]) bit_half_period[7:0]  <= w_data[7:0];
                    if (w_strb[1]) bit_half_period[15:8] <= w_data[15:8];
                end
                `ADDR_ENERGY_THRESHOLD:
                    if (w_strb[0]) energy_threshold <= w_data[5:0];
                default: ;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// Transmit port
reg  [1:0]  tx_state;
reg         tx_power_enable_prev;
reg         tx_clk;
reg  [15:0] tx_div;
reg  [15:0] pre_left;
wire        tx_int_mode;
wire [7:0]  tx_lead;

assign tx_int_mode = tx_control[`TXC_INT_PREAMBLE_BIT];
assign tx_lead     = tx_control[`TXC_LEAD_MSB:`TXC_LEAD_LSB];

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        tx_state         <= TX_IDLE;
        tx_power_enable_prev       <= 1'b0;
        tx_clk           <= 1'b0;
        tx_div           <= 16'h0000;
        pre_left         <= 16'h0000;
        tx_bit_out       <= 1'b0;
        tx_bit_strobe    <= 1'b0;
        tx_data_phase    <= 1'b0;
        tx_ready         <= 1'b0;
        tx_bit_clock_out <= 1'b0;
    end else begin
        tx_power_enable_prev    <= tx_power_enable_eff;
        tx_bit_strobe <= 1'b0;
        case (tx_state)
            TX_IDLE: begin
                tx_clk <= 1'b0;
                // Enable alone starts the packet, clear channel unused
                if (tx_power_enable_eff && !tx_power_enable_prev) begin
                    tx_div   <= half_eff - 16'h0001;
                    pre_left <= tx_control[`TXC_PRE_LEN_MSB:`TXC_PRE_LEN_LSB];
                    if (tx_int_mode)
                        tx_state <= TX_PREAMBLE;
                    else
                        tx_state <= TX_DATA;
                end
            end
            TX_PREAMBLE, TX_DATA: begin
                if (!tx_power_enable_eff) begin
                    tx_state <= TX_IDLE;
                    tx_clk   <= 1'b0;
                end else begin
                    tx_div <= div_next(tx_div, half_eff);
                    if (tx_div == 16'h0000) begin
                        tx_clk <= !tx_clk;
                        if (tx_clk) begin
                            tx_bit_strobe <= 1'b1;
                            if (tx_state == TX_DATA) begin
                                tx_bit_out <= tx_data_sync;
                            end else begin
                                tx_bit_out <= 1'b1;
                                if (pre_left <= 16'h0001)
                                    tx_state <= TX_DATA;
                                else
                                    pre_left <= pre_left - 16'h0001;
                            end
                        end
                    end
                end
            end
            default: tx_state <= TX_IDLE;
        endcase
        tx_data_phase <= (tx_state == TX_DATA);
        tx_ready <= (tx_int_mode && tx_power_enable_eff &&
                     ((tx_state == TX_DATA) ||
                      (tx_state == TX_PREAMBLE &&
                       pre_left <= {8'h00, tx_lead})))
                    ^ io_polarity_config[`POL_TX_READY_LOW_BIT];
        tx_bit_clock_out <= tx_clk ^
                    io_polarity_config[`POL_TX_CLOCK_LOW_BIT];
    end
end

// Receive port, runs from its own enable and divider
reg         rx_clk;
reg  [15:0] rx_div;
reg         rx_valid_int;
reg  [15:0] rx_left;
reg         rx_pending;
wire        rx_live;
wire        ed_now;

assign rx_live = rx_power_enable_eff && acq_achieved;
assign ed_now  = rssi_value > energy_threshold;

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        rx_clk               <= 1'b0;
        rx_div               <= 16'h0000;
        rx_valid_int         <= 1'b0;
        rx_left              <= 16'h0000;
        rx_pending           <= 1'b0;
        rx_bit_clock_out     <= 1'b0;
        rx_data_out          <= 1'b0;
        rx_data_valid        <= 1'b0;
        energy_detect_ind    <= 1'b0;
        carrier_acquired_ind <= 1'b0;
        clear_channel_ind    <= 1'b0;
    end else begin
        if (!rx_live) begin
            rx_clk       <= 1'b0;
            rx_div       <= half_eff - 16'h0001;
            rx_valid_int <= 1'b0;
        end else begin
            if (demod_strobe)
                rx_pending <= demod_bit;
            if (hdr_strobe && !rx_valid_int &&
                (hdr_crc_ok ||
                 modem_config_c[`CFGC_CRC_IGNORE_BIT])) begin
                rx_valid_int <= 1'b1;
                rx_left      <= hdr_length;
            end
            rx_div <= div_next(rx_div, half_eff);
            if (rx_div == 16'h0000) begin
                rx_clk <= !rx_clk;
                if (rx_clk) begin
                    rx_data_out <= rx_pending;
                    if (rx_valid_int) begin
                        if (rx_left == 16'h0000)
                            rx_valid_int <= 1'b0;
                        else
                            rx_left <= rx_left - 16'h0001;
                    end
                end
            end
            if (pn_track_lost)
                rx_valid_int <= 1'b0;
        end
        rx_bit_clock_out <= rx_clk;
        rx_data_valid <= (rx_valid_int && rx_live && !pn_track_lost) ^
                    io_polarity_config[`POL_RX_VALID_LOW_BIT];
        energy_detect_ind    <= ed_now;
        carrier_acquired_ind <= rx_live;
        clear_channel_ind    <= !ed_now;
    end
end

// AXI4-Lite read path, one cycle to answer
reg [31:0] rd_value;
reg        rd_ok;

always @* begin
    rd_value = 32'h0000_0000;
    rd_ok    = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
        `ADDR_MODEM_CONFIG_C:   rd_value = {24'h00_0000, modem_config_c};
        `ADDR_IO_POLARITY:      rd_value = {24'h00_0000, io_polarity_config};
        `ADDR_TX_CONTROL:       rd_value = tx_control;
        `ADDR_BIT_HALF_PERIOD:  rd_value = {16'h0000, bit_half_period};
        `ADDR_ENERGY_THRESHOLD: rd_value = {26'h000_0000, energy_threshold};
        `ADDR_PORT_STATUS:
            rd_value = {rx_left, 8'h00, tx_state, tx_power_enable_eff, rx_power_enable_eff,
                        rx_valid_int, ed_now, rx_live, tx_clk};
        default:                rd_ok    = 1'b0;
    endcase
end

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

// File: verilog/sync_two_flop.v
// Two flip-flop synchroniser for levels arriving from outside the clock domain
module sync_two_flop #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage_one;

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        stage_one <= {WIDTH{1'b0}};
        sync_out  <= {WIDTH{1'b0}};
    end else begin
        stage_one <= async_in;
        sync_out  <= stage_one;
    end
end

endmodule
